// [include/sbs_defs.vh]
// constants for the bank select and subtract-with-borrow block
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH

// register byte offsets on the avalon slave
`define SBS_OFF_CTRL       12'h000
`define SBS_OFF_INSN       12'h004
`define SBS_OFF_FLAGS      12'h008
`define SBS_OFF_WRBASE     12'h00C
`define SBS_OFF_STATUS     12'h010
`define SBS_RF_BASE_HI     2'h1

// control register bit positions
`define SBS_CTRL_GO        0
`define SBS_CTRL_CLR_DONE  1
`define SBS_CTRL_CLR_ILL   2

// status register bit positions
`define SBS_STAT_BUSY      0
`define SBS_STAT_DONE      1
`define SBS_STAT_ILL       2

// flag register bit positions
`define SBS_FLAG_C         7
`define SBS_FLAG_Z         6
`define SBS_FLAG_S         5
`define SBS_FLAG_V         4
`define SBS_FLAG_D         3
`define SBS_FLAG_H         2
`define SBS_FLAG_BANK      0

// reset values
`define SBS_RST_FLAGS      8'h00
`define SBS_RST_WRBASE     8'h00
`define SBS_RST_INSN       24'h000000

// opcodes
`define SBS_SELECT_BANK_ZERO_OP    8'h4F
`define SBS_SELECT_BANK_ONE_OP     8'h5F
`define SBS_SUB_BORROW_OP_WR_WR    8'h32
`define SBS_SUB_BORROW_OP_WR_IWR   8'h33
`define SBS_SUB_BORROW_OP_R_R      8'h34
`define SBS_SUB_BORROW_OP_R_IR     8'h35
`define SBS_SUB_BORROW_OP_R_IM     8'h36

// execution time in core cycles
`define SBS_CYC_BANK       3'h4
`define SBS_CYC_SHORT      3'h4
`define SBS_CYC_LONG       3'h6

`endif

// [hw/sbs_sub_alu.v]
// eight-bit subtract with borrow and its flag results
`timescale 1ns/1ns
module sbs_sub_alu (
  // operands
  input  wire [7:0] dst_val,
  input  wire [7:0] src_val,
  input  wire       borrow_in,
  // results
  output wire [7:0] result,
  output wire       flag_c,
  output wire       flag_z,
  output wire       flag_s,
  output wire       flag_v,
  output wire       flag_h
);

  wire [8:0] diff9;
  wire [4:0] diff5;

  // carry in acts as a borrow so multi-byte chains work
  assign diff9  = {1'b0, dst_val} - {1'b0, src_val} - {8'h00, borrow_in};
  assign diff5  = {1'b0, dst_val[3:0]} - {1'b0, src_val[3:0]} - {4'h0, borrow_in};
  assign result = diff9[7:0];

  assign flag_c = diff9[8];
  assign flag_z = (diff9[7:0] == 8'h00);
  assign flag_s = diff9[7];
  assign flag_v = (dst_val[7] ^ src_val[7]) & (diff9[7] == src_val[7]);
  assign flag_h = diff5[4];

endmodule // sbs_sub_alu

// [hw/sbs_regfile.v]
// byte register file with two asynchronous read ports and one write port
`timescale 1ns/1ns
module sbs_regfile #(
  parameter AW = 8
) (
  // clock
  input  wire          mclk,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  // read ports
  input  wire [AW-1:0] rd_a_addr,
  output wire [7:0]    rd_a_data,
  input  wire [AW-1:0] rd_b_addr,
  output wire [7:0]    rd_b_data
);

  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_a_data = mem[rd_a_addr];
  assign rd_b_data = mem[rd_b_addr];

endmodule // sbs_regfile

// [hw/sbs_core.v]
// bank select and subtract-with-borrow execution unit with avalon register slave
//
// Behaviour
// - bank zero opcode clears flag bit 0, 4 cycles
// - bank one opcode sets flag bit 0, 4 cycles
// - destination minus source minus carry, stored back
// - source location is never written
// - carry in serves as the borrow
// - carry set on borrow, cleared otherwise
// - zero on zero result, sign from bit 7
// - overflow on opposite signs, result follows source
// - decimal flag forced one, half flag means borrow
`timescale 1ns/1ns
`include "sbs_defs.vh"
module sbs_core (
  // clock and reset
  input  wire        mclk,
  input  wire        srst,
  // avalon-mm slave
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // core state
  output wire [7:0]  flags,
  output wire        busy
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_OPND = 4'b0100;
  localparam ST_EXEC = 4'b1000;

  // cycle count of an opcode, zero when the opcode is not handled
  function [2:0] op_cycles;
    input [7:0] op;
    begin
      case (op)
        `SBS_SELECT_BANK_ZERO_OP:  op_cycles = `SBS_CYC_BANK;
        `SBS_SELECT_BANK_ONE_OP:   op_cycles = `SBS_CYC_BANK;
        `SBS_SUB_BORROW_OP_WR_WR:  op_cycles = `SBS_CYC_SHORT;
        `SBS_SUB_BORROW_OP_WR_IWR: op_cycles = `SBS_CYC_LONG;
        `SBS_SUB_BORROW_OP_R_R:    op_cycles = `SBS_CYC_LONG;
        `SBS_SUB_BORROW_OP_R_IR:   op_cycles = `SBS_CYC_LONG;
        `SBS_SUB_BORROW_OP_R_IM:   op_cycles = `SBS_CYC_LONG;
        default:                   op_cycles = 3'h0;
      endcase
    end
  endfunction

  // working register nibble to full register address
  function [7:0] wr_addr;
    input [7:0] base;
    input [3:0] n;
    begin
      wr_addr = {base[7:4], n};
    end
  endfunction

  // state
  reg  [3:0]  st_q;
  reg  [2:0]  cnt_q;
  reg  [2:0]  ncyc_q;
  reg  [7:0]  flags_q;
  reg  [7:0]  wrbase_q;
  reg  [23:0] insn_q;
  reg  [7:0]  src_addr_q;
  reg  [7:0]  dst_addr_q;
  reg  [7:0]  src_val_q;
  reg  [7:0]  dst_val_q;
  reg  [7:0]  result_q;
  reg         done_q;
  reg         ill_q;
  reg         ack_q;
  reg  [31:0] rdata_q;

  // decode helpers
  wire [7:0]  op_w;
  wire [7:0]  b1_w;
  wire [7:0]  b2_w;
  wire [2:0]  go_cyc;
  wire        is_sub;
  wire        busy_w;

  assign op_w   = insn_q[7:0];
  assign b1_w   = insn_q[15:8];
  assign b2_w   = insn_q[23:16];
  assign go_cyc = op_cycles(op_w);
  assign is_sub = (op_w != `SBS_SELECT_BANK_ZERO_OP) && (op_w != `SBS_SELECT_BANK_ONE_OP);
  assign busy_w = (st_q != ST_IDLE);

  // bus decode
  wire        req;
  wire        sel_ctrl;
  wire        sel_insn;
  wire        sel_flags;
  wire        sel_wrbase;
  wire        sel_status;
  wire        sel_rf;
  wire        blocked;
  wire        ack_d;
  wire        take;
  wire        wr_take;

  assign req        = avs_read | avs_write;
  assign sel_ctrl   = (avs_address == `SBS_OFF_CTRL);
  assign sel_insn   = (avs_address == `SBS_OFF_INSN);
  assign sel_flags  = (avs_address == `SBS_OFF_FLAGS);
  assign sel_wrbase = (avs_address == `SBS_OFF_WRBASE);
  assign sel_status = (avs_address == `SBS_OFF_STATUS);
  assign sel_rf     = (avs_address[11:10] == `SBS_RF_BASE_HI) && (avs_address[1:0] == 2'h0);
  // while an instruction runs only control and status can be reached
  assign blocked    = busy_w & ~(sel_ctrl | sel_status);
  assign ack_d      = req & ~ack_q & ~blocked;
  assign take       = req & ack_q;
  assign wr_take    = take & avs_write;

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign flags           = flags_q;
  assign busy            = busy_w;

  // register file hookup
  wire        exec_last;
  wire        exec_wr;
  wire        rf_we;
  wire [7:0]  rf_waddr;
  wire [7:0]  rf_wdata;
  wire [7:0]  rd_a_addr;
  wire [7:0]  rd_a_data;
  wire [7:0]  rd_b_data;
  wire [7:0]  ptr_addr;
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_z;
  wire        alu_s;
  wire        alu_v;
  wire        alu_h;

  assign exec_last = (st_q == ST_EXEC) && (cnt_q == ncyc_q);
  assign exec_wr   = exec_last & is_sub;
  // only the destination address is ever written by execution
  assign rf_we     = exec_wr | (wr_take & sel_rf & avs_byteenable[0]);
  assign rf_waddr  = exec_wr ? dst_addr_q : avs_address[9:2];
  assign rf_wdata  = exec_wr ? alu_res : avs_writedata[7:0];
  // pointer fetch for the indirect source forms
  assign ptr_addr  = (op_w == `SBS_SUB_BORROW_OP_WR_IWR) ? wr_addr(wrbase_q, b1_w[3:0]) : b1_w;
  assign rd_a_addr = (st_q == ST_ADDR) ? ptr_addr :
                     (st_q == ST_OPND) ? src_addr_q : avs_address[9:2];

  sbs_regfile #(
    .AW (8)
  ) u_rf (
    .mclk      (mclk),
    .wr_en     (rf_we),
    .wr_addr   (rf_waddr),
    .wr_data   (rf_wdata),
    .rd_a_addr (rd_a_addr),
    .rd_a_data (rd_a_data),
    .rd_b_addr (dst_addr_q),
    .rd_b_data (rd_b_data)
  );

  sbs_sub_alu u_alu (
    .dst_val   (dst_val_q),
    .src_val   (src_val_q),
    .borrow_in (flags_q[`SBS_FLAG_C]),
    .result    (alu_res),
    .flag_c    (alu_c),
    .flag_z    (alu_z),
    .flag_s    (alu_s),
    .flag_v    (alu_v),
    .flag_h    (alu_h)
  );

  // read data mux
  reg  [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (sel_ctrl | sel_status) begin
      rd_mux[`SBS_STAT_BUSY] = busy_w;
      rd_mux[`SBS_STAT_DONE] = done_q;
      rd_mux[`SBS_STAT_ILL]  = ill_q;
      if (sel_status) begin
        rd_mux[15:8] = result_q;
      end
    end else if (sel_insn) begin
      rd_mux[23:0] = insn_q;
    end else if (sel_flags) begin
      rd_mux[7:0] = flags_q;
    end else if (sel_wrbase) begin
      rd_mux[7:0] = wrbase_q;
    end else if (sel_rf) begin
      rd_mux[7:0] = rd_a_data;
    end
  end

  // go, clear and sticky events
  wire        go;
  wire        clr_done;
  wire        clr_ill;

  assign go       = wr_take & sel_ctrl & avs_byteenable[0] & avs_writedata[`SBS_CTRL_GO] & ~busy_w;
  assign clr_done = wr_take & sel_ctrl & avs_byteenable[0] & avs_writedata[`SBS_CTRL_CLR_DONE];
  assign clr_ill  = wr_take & sel_ctrl & avs_byteenable[0] & avs_writedata[`SBS_CTRL_CLR_ILL];

  // bus side registers
  always @(posedge mclk) begin
    if (srst) begin
      ack_q    <= 1'b0;
      rdata_q  <= 32'h00000000;
      insn_q   <= `SBS_RST_INSN;
      wrbase_q <= `SBS_RST_WRBASE;
    end else begin
      ack_q <= ack_d;
      if (ack_d & avs_read) begin
        rdata_q <= rd_mux;
      end
      if (wr_take & sel_insn) begin
        if (avs_byteenable[0]) begin
          insn_q[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          insn_q[15:8] <= avs_writedata[15:8];
        end
        if (avs_byteenable[2]) begin
          insn_q[23:16] <= avs_writedata[23:16];
        end
      end
      if (wr_take & sel_wrbase & avs_byteenable[0]) begin
        wrbase_q <= avs_writedata[7:0];
      end
    end
  end

  // sticky status, a set in the same cycle as its clear wins
  always @(posedge mclk) begin
    if (srst) begin
      done_q <= 1'b0;
      ill_q  <= 1'b0;
    end else begin
      if (exec_last) begin
        done_q <= 1'b1;
      end else if (clr_done) begin
        done_q <= 1'b0;
      end
      if (go && (go_cyc == 3'h0)) begin
        ill_q <= 1'b1;
      end else if (clr_ill) begin
        ill_q <= 1'b0;
      end
    end
  end

  // instruction sequencer
  always @(posedge mclk) begin
    if (srst) begin
      st_q       <= ST_IDLE;
      cnt_q      <= 3'h0;
      ncyc_q     <= 3'h0;
      src_addr_q <= 8'h00;
      dst_addr_q <= 8'h00;
      src_val_q  <= 8'h00;
      dst_val_q  <= 8'h00;
      result_q   <= 8'h00;
      flags_q    <= `SBS_RST_FLAGS;
    end else begin
      if (st_q != ST_IDLE) begin
        cnt_q <= cnt_q + 3'h1;
      end
      case (st_q)
        ST_IDLE: begin
          if (go && (go_cyc != 3'h0)) begin
            st_q   <= ST_ADDR;
            cnt_q  <= 3'h1;
            ncyc_q <= go_cyc;
          end else if (wr_take & sel_flags & avs_byteenable[0]) begin
            flags_q <= avs_writedata[7:0];
          end
        end
        ST_ADDR: begin
          st_q <= ST_OPND;
          case (op_w)
            `SBS_SUB_BORROW_OP_WR_WR: begin
              dst_addr_q <= wr_addr(wrbase_q, b1_w[7:4]);
              src_addr_q <= wr_addr(wrbase_q, b1_w[3:0]);
            end
            `SBS_SUB_BORROW_OP_WR_IWR: begin
              dst_addr_q <= wr_addr(wrbase_q, b1_w[7:4]);
              src_addr_q <= rd_a_data;
            end
            `SBS_SUB_BORROW_OP_R_R: begin
              src_addr_q <= b1_w;
              dst_addr_q <= b2_w;
            end
            `SBS_SUB_BORROW_OP_R_IR: begin
              src_addr_q <= rd_a_data;
              dst_addr_q <= b2_w;
            end
            `SBS_SUB_BORROW_OP_R_IM: begin
              dst_addr_q <= b1_w;
              src_addr_q <= 8'h00;
            end
            default: begin
              src_addr_q <= src_addr_q;
            end
          endcase
        end
        ST_OPND: begin
          st_q      <= ST_EXEC;
          dst_val_q <= rd_b_data;
          src_val_q <= (op_w == `SBS_SUB_BORROW_OP_R_IM) ? b2_w : rd_a_data;
        end
        ST_EXEC: begin
          if (exec_last) begin
            st_q <= ST_IDLE;
            if (op_w == `SBS_SELECT_BANK_ZERO_OP) begin
              flags_q[`SBS_FLAG_BANK] <= 1'b0;
            end else if (op_w == `SBS_SELECT_BANK_ONE_OP) begin
              flags_q[`SBS_FLAG_BANK] <= 1'b1;
            end else begin
              result_q             <= alu_res;
              flags_q[`SBS_FLAG_C] <= alu_c;
              flags_q[`SBS_FLAG_Z] <= alu_z;
              flags_q[`SBS_FLAG_S] <= alu_s;
              flags_q[`SBS_FLAG_V] <= alu_v;
              flags_q[`SBS_FLAG_D] <= 1'b1;
              flags_q[`SBS_FLAG_H] <= alu_h;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sbs_core

// [bench/sbs_core_assertions.sv]
// concurrent checks on the ports of the bank select and subtract-with-borrow core
`timescale 1ns/1ns
`include "sbs_defs.vh"
module sbs_core_chk (
  // clock and reset
  input wire        mclk,
  input wire        srst,
  // register bus
  input wire [11:0] avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // core state
  input wire [7:0]  flags,
  input wire        busy
);
  reg  [7:0] op_q;
  reg  [7:0] run_q;
  wire       wr_done = avs_write & ~avs_waitrequest;
  wire       go      = wr_done & ~busy & (avs_address == `SBS_OFF_CTRL) & avs_writedata[0];
  wire       is_sub  = (run_q >= 8'h32) & (run_q <= 8'h36);
  wire       long_op = (op_q >= 8'h33) & (op_q <= 8'h36);
  wire       legal   = long_op | (op_q == 8'h32) | (op_q == 8'h4F) | (op_q == 8'h5F);

  // staged opcode, and the opcode last started until flags are rewritten by software
  always @(posedge mclk) begin
    if (srst) begin
      op_q  <= 8'h00;
      run_q <= 8'h00;
    end else begin
      if (wr_done & avs_byteenable[0] & (avs_address == `SBS_OFF_INSN))
        op_q <= avs_writedata[7:0];
      if (go)
        run_q <= op_q;
      else if (wr_done & (avs_address == `SBS_OFF_FLAGS))
        run_q <= 8'h00;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  bank_zero_a: assert property (
    go && op_q == 8'h4F |=> busy [*4] ##1 (!busy && !flags[0] && flags[7:1] == $past(flags[7:1], 5)))
    else $error("bank zero opcode misbehaved");
  bank_one_a: assert property (
    go && op_q == 8'h5F |=> busy [*4] ##1 (!busy && flags[0] && flags[7:1] == $past(flags[7:1], 5)))
    else $error("bank one opcode misbehaved");
  short_time_a: assert property (go && op_q == 8'h32 |=> busy [*4] ##1 !busy)
    else $error("short form took the wrong time");
  long_time_a: assert property (go && long_op |=> busy [*6] ##1 !busy)
    else $error("long form took the wrong time");
  ill_idle_a: assert property (go && !legal |=> !busy [*2])
    else $error("unknown opcode started");
  dec_flag_a: assert property ($fell(busy) && is_sub |-> flags[3] && flags[1:0] == $past(flags[1:0]))
    else $error("decimal flag or low flag bits wrong");
  flag_hold_a: assert property (busy && $past(busy) |-> $stable(flags))
    else $error("flags moved during execution");
  zero_sign_a: assert property (
    avs_read && !avs_waitrequest && !busy && is_sub && avs_address == `SBS_OFF_STATUS
    |-> flags[6] == (avs_readdata[15:8] == 8'h00) && flags[5] == avs_readdata[15]) else $error("zero or sign flag wrong");

  bank_c: cover property (go && op_q == 8'h5F);
  sub_c: cover property ($fell(busy) && is_sub);
  stall_c: cover property (busy && avs_read && avs_waitrequest && avs_address == `SBS_OFF_FLAGS);
endmodule // sbs_core_chk

bind sbs_core sbs_core_chk sbs_core_chk_inst (
  .mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .flags(flags), .busy(busy));

// [bench/sbs_core_tb_top.sv]
// self-checking bench for the bank select and subtract-with-borrow core
`timescale 1ns/1ns
`include "sbs_defs.vh"
module sbs_core_tb_top;
  reg         mclk           = 1'b0;
  reg         srst           = 1'b1;
  reg  [11:0] avs_address    = 12'h000;
  reg         avs_read       = 1'b0;
  reg         avs_write      = 1'b0;
  reg  [31:0] avs_writedata  = 32'h00000000;
  reg  [3:0]  avs_byteenable = 4'hF;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire [7:0]  flags;
  wire        busy;
  integer     err_count      = 0;
  integer     checked        = 0;
  reg  [31:0] rd;

  always #5 mclk = ~mclk;

  sbs_core sbs_core_inst (
    .mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flags(flags), .busy(busy));

  task wrap_up;
    begin
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task cmp8(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // one bus access; request held until waitrequest is sampled low
  task bus(input wr, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      k = 0;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) begin
        k = k + 1;
        if (k > 40) begin
          err_count = err_count + 1;
          $display("[ERR] %0t bus access never answered", $time);
          wrap_up;
        end
        @(posedge mclk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
    end
  endtask

  task wm(input [7:0] i, input [7:0] v);
    bus(1'b1, {`SBS_RF_BASE_HI, i, 2'b00}, {24'h0, v});
  endtask

  task rm(input [7:0] i);
    bus(1'b0, {`SBS_RF_BASE_HI, i, 2'b00}, 32'h0);
  endtask

  // stage and start an instruction, then count the cycles busy stays high
  task run(input [7:0] op, input [7:0] b1, input [7:0] b2, input [7:0] n);
    integer k;
    begin
      bus(1'b1, `SBS_OFF_INSN, {8'h00, b2, b1, op});
      bus(1'b1, `SBS_OFF_CTRL, 32'h1);
      k = 0;
      @(posedge mclk);
      while (busy === 1'b1) begin
        k = k + 1;
        if (k > 20) begin
          err_count = err_count + 1;
          $display("[ERR] %0t instruction never finished", $time);
          wrap_up;
        end
        @(posedge mclk);
      end
      cmp8(k[7:0], n);
    end
  endtask

  task swb(input [7:0] op, b1, b2, da, dv, sa, sv, input cin, input [7:0] n);
    reg [8:0] r;
    reg       h;
    begin
      wm(da, dv);
      if (op != 8'h36)
        wm(sa, sv);
      bus(1'b1, `SBS_OFF_FLAGS, {24'h0, cin, 7'h02});
      run(op, b1, b2, n);
      r = {1'b0, dv} - {1'b0, sv} - {8'h00, cin};
      h = {1'b0, dv[3:0]} < ({1'b0, sv[3:0]} + {4'h0, cin});
      cmp8(flags & 8'h80, {r[8], 7'h00});
      cmp8(flags & 8'h60, {1'b0, r[7:0] == 8'h00, r[7], 5'h00});
      cmp8(flags & 8'h10, {3'h0, (dv[7] ^ sv[7]) & (r[7] == sv[7]), 4'h0});
      cmp8(flags & 8'h0F, {4'h0, 1'b1, h, 2'b10});
      bus(1'b0, `SBS_OFF_STATUS, 32'h0);
      cmp8(rd[15:8], r[7:0]);
      rm(da);
      cmp8(rd[7:0], r[7:0]);
      if (op != 8'h36) begin
        rm(sa);
        cmp8(rd[7:0], sv);
      end
    end
  endtask

  task sc_reset;
    begin
      cmp8(flags, 8'h00);
      bus(1'b0, `SBS_OFF_INSN, 32'h0);
      cmp8(rd[7:0], 8'h00);
      bus(1'b1, 12'h020, 32'hFF);
      bus(1'b0, 12'h020, 32'h0);
      cmp8(rd[7:0], 8'h00);
    end
  endtask

  task sc_bank;
    begin
      bus(1'b1, `SBS_OFF_FLAGS, 32'hFF);
      run(8'h4F, 8'h00, 8'h00, 8'h04);
      cmp8(flags, 8'hFE);
      bus(1'b1, `SBS_OFF_FLAGS, 32'h00);
      run(8'h5F, 8'h00, 8'h00, 8'h04);
      cmp8(flags, 8'h01);
    end
  endtask

  task sc_forms;
    begin
      bus(1'b1, `SBS_OFF_WRBASE, 32'h10);
      swb(8'h32, 8'h12, 8'h00, 8'h11, 8'h10, 8'h12, 8'h03, 1'b1, 8'h04);
      wm(8'h12, 8'h03);
      swb(8'h33, 8'h12, 8'h00, 8'h11, 8'h10, 8'h03, 8'h0A, 1'b1, 8'h06);
      swb(8'h34, 8'h02, 8'h01, 8'h01, 8'h20, 8'h02, 8'h03, 1'b1, 8'h06);
      swb(8'h35, 8'h02, 8'h01, 8'h01, 8'h20, 8'h03, 8'h0A, 1'b1, 8'h06);
      swb(8'h36, 8'h01, 8'h8A, 8'h01, 8'h20, 8'h00, 8'h8A, 1'b1, 8'h06);
      swb(8'h34, 8'h02, 8'h01, 8'h01, 8'h01, 8'h02, 8'h00, 1'b1, 8'h06);
      swb(8'h32, 8'h12, 8'h00, 8'h11, 8'h7F, 8'h12, 8'h80, 1'b0, 8'h04);
      swb(8'h36, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 1'b0, 8'h06);
      swb(8'h36, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 1'b1, 8'h06);
    end
  endtask

  task sc_stall;
    begin
      bus(1'b1, `SBS_OFF_FLAGS, 32'h0);
      bus(1'b1, `SBS_OFF_INSN, 32'h008A0136);
      bus(1'b1, `SBS_OFF_CTRL, 32'h1);
      bus(1'b0, `SBS_OFF_STATUS, 32'h0);
      cmp8(rd[7:0] & 8'h01, 8'h01);
      bus(1'b0, `SBS_OFF_FLAGS, 32'h0);
      cmp8({7'h00, busy}, 8'h00);
      cmp8(rd[7:0] & 8'h08, 8'h08);
    end
  endtask

  task sc_illegal;
    begin
      bus(1'b1, `SBS_OFF_FLAGS, 32'h5A);
      run(8'h37, 8'h00, 8'h00, 8'h00);
      bus(1'b0, `SBS_OFF_STATUS, 32'h0);
      cmp8(rd[7:0] & 8'h04, 8'h04);
      cmp8(rd[7:0] & 8'h02, 8'h02);
      cmp8(flags, 8'h5A);
      bus(1'b1, `SBS_OFF_CTRL, 32'h6);
      bus(1'b0, `SBS_OFF_STATUS, 32'h0);
      cmp8(rd[7:0] & 8'h04, 8'h00);
      cmp8(rd[7:0] & 8'h02, 8'h00);
    end
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    sc_reset;
    sc_bank;
    sc_forms;
    sc_stall;
    sc_illegal;
    wrap_up;
  end
endmodule // sbs_core_tb_top
